// ===== pkg/icoc_pkg.sv
package icoc_pkg;

    localparam int NCH = 8;

    // Global register byte offsets
    localparam logic [7:0] OFF_COUNT  = 8'h00;
    localparam logic [7:0] OFF_CTRL0  = 8'h04;
    localparam logic [7:0] OFF_CTRL1  = 8'h08;
    localparam logic [7:0] OFF_DIV    = 8'h0C;
    localparam logic [7:0] OFF_RSTVAL = 8'h10;
    localparam logic [7:0] OFF_PCLK   = 8'h14;
    localparam logic [7:0] OFF_FSEL   = 8'h18;
    localparam logic [7:0] OFF_FEN    = 8'h1C;

    // Register groups, haddr[7:5]; channel index in haddr[4:2]
    localparam logic [2:0] GRP_GLOBAL = 3'h0;
    localparam logic [2:0] GRP_CMP    = 3'h1;
    localparam logic [2:0] GRP_WCTL   = 3'h2;
    localparam logic [2:0] GRP_MCTL   = 3'h3;
    localparam logic [2:0] GRP_CAP    = 3'h4;
    localparam logic [2:0] GRP_PRB    = 3'h5;

    // Field positions
    localparam int C0_CSS   = 0;
    localparam int C0_RREN  = 2;
    localparam int C0_OVSEL = 3;
    localparam int C1_CREN  = 0;
    localparam int C1_PREN  = 1;
    localparam int C1_RUN   = 4;
    localparam int C1_MODE  = 5;
    localparam int W_INV    = 2;
    localparam int W_IVL    = 3;
    localparam int M_GATE   = 4;
    localparam int M_GCLR   = 5;
    localparam int M_PRE    = 6;
    localparam int M_PN     = 8;

    localparam logic [15:0] MCTL_LO_MASK = 16'h0003;
    localparam logic [15:0] MCTL_HI_MASK = 16'hFF53;
    localparam logic [2:0]  PRE_CH_LO    = 3'h6;
    localparam logic [15:0] COUNT_ZERO   = 16'h0000;
    localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
    localparam logic [15:0] COUNT_ONE    = 16'h0001;
    localparam logic [14:0] LOW15_MAX    = 15'h7FFF;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic        HRESP_OKAY    = 1'b0;

    typedef enum logic [1:0] {CSS_STOP = 2'h0, CSS_PCLK = 2'h1, CSS_TWO_PHASE = 2'h2, CSS_PCLK_ALT = 2'h3} icoc_css_t;
    typedef enum logic [1:0] {CM_UP = 2'h0, CM_UPDOWN = 2'h1, CM_TWO_PHASE = 2'h2, CM_RSVD = 2'h3} icoc_cmode_t;
    typedef enum logic [1:0] {OM_SINGLE = 2'h0, OM_DELAY = 2'h1, OM_SR = 2'h2, OM_RSVD = 2'h3} icoc_omode_t;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } icoc_ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
    } icoc_ahb_rsp_t;

    typedef struct packed {
        logic [15:0]       count;
        logic              down;
        logic [7:0]        div_cnt;
        logic              f2_ph;
        logic              qa;
        logic              qb;
        logic [1:0]        css;
        logic              rren;
        logic              ovsel;
        logic              cren;
        logic              pren;
        logic              run;
        logic [1:0]        mode;
        logic [7:0]        div;
        logic [15:0]       rstval;
        logic              pclk_sel;
        logic [7:0]        fsel;
        logic [7:0]        fen;
        logic [7:0][15:0]  cmp;
        logic [7:0][3:0]   wctl;
        logic [7:0][15:0]  mctl;
        logic [7:0][15:0]  cap;
        logic [1:0][15:0]  prb;
        logic [1:0][7:0]   pre_cnt;
        logic [1:0]        gate_closed;
        logic [7:0]        chin;
        logic [7:0]        wave;
        logic [7:0]        pin;
        logic [7:0]        drive;
        logic              wr_act;
        logic              wr_ok;
        logic [7:0]        wr_addr;
        logic [31:0]       hrdata;
        logic              irq_req;
    } icoc_state_t;

endpackage

// ===== core/icoc_base_timer.sv
`timescale 1ns/10ps
module icoc_base_timer
(
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire icoc_pkg::icoc_ahb_req_t ahb_req,
    output icoc_pkg::icoc_ahb_rsp_t      ahb_rsp,
    input  wire logic                    phase_a_input,
    input  wire logic                    phase_b_input,
    input  wire logic                    external_reset_pin,
    input  wire logic [7:0]              chan_in,
    output logic [7:0]                   chan_out,
    output logic [7:0]                   chan_oe_n,
    output logic                         base_irq_req
);
    import icoc_pkg::*;

    icoc_state_t s;
    icoc_state_t n;

    logic        periph_en;
    logic        q_evt;
    logic        q_up;
    logic        src_evt;
    logic        tick;
    logic        step_up;
    logic        ovf;
    logic        rmatch;
    logic        cmp_rst_ok;
    logic        rst_evt;
    logic        addr_phase;
    logic        wr_hit;
    logic        active;
    logic        rise;
    logic        fall;
    logic [15:0] cnt_nx;
    logic [7:0]  match;
    logic [7:0]  trig;
    logic [31:0] rdat;
    logic [2:0]  ch;
    logic [2:0]  rch;

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign ahb_rsp.hrdata    = s.hrdata;
    assign ahb_rsp.hreadyout = 1'b1;
    assign ahb_rsp.hresp     = HRESP_OKAY;
    assign chan_out          = s.pin;
    assign chan_oe_n         = ~s.drive;
    assign base_irq_req      = s.irq_req;

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        n          = s;
        n.irq_req  = 1'b0;
        rdat       = '0;
        rch        = ahb_req.haddr[4:2];
        ch         = s.wr_addr[4:2];
        step_up    = 1'b1;
        tick       = 1'b0;
        rst_evt    = 1'b0;
        match      = '0;
        trig       = '0;
        active     = 1'b0;
        rise       = 1'b0;
        fall       = 1'b0;

        // Count source
        n.f2_ph   = ~s.f2_ph;
        periph_en = s.pclk_sel ? 1'b1 : s.f2_ph;
        q_evt     = (phase_a_input ^ s.qa) ^ (phase_b_input ^ s.qb);
        q_up      = (phase_a_input ^ s.qa) ? (phase_a_input != phase_b_input)
                                           : (phase_b_input == phase_a_input);
        n.qa      = phase_a_input;
        n.qb      = phase_b_input;
        case (s.css)
            CSS_STOP:      src_evt = 1'b0;
            CSS_TWO_PHASE: src_evt = q_evt;
            default:       src_evt = periph_en;
        endcase

        // Divider by n+1
        if (s.run && src_evt)
        begin
            if (s.div_cnt >= s.div)
            begin
                n.div_cnt = '0;
                tick      = 1'b1;
            end
            else
            begin
                n.div_cnt = s.div_cnt + 8'h01;
            end
        end

        // Counter step
        cnt_nx = s.count;
        if (tick)
        begin
            case (s.mode)
                CM_UPDOWN:
                begin
                    if (!s.down)
                    begin
                        if (s.count == COUNT_MAX)
                        begin
                            n.down  = 1'b1;
                            step_up = 1'b0;
                            cnt_nx  = s.count - COUNT_ONE;
                        end
                        else
                        begin
                            cnt_nx = s.count + COUNT_ONE;
                        end
                    end
                    else if (s.count == COUNT_ZERO)
                    begin
                        n.down = 1'b0;
                        cnt_nx = COUNT_ONE;
                    end
                    else
                    begin
                        step_up = 1'b0;
                        cnt_nx  = s.count - COUNT_ONE;
                    end
                end
                CM_TWO_PHASE:
                begin
                    step_up = q_up;
                    cnt_nx  = q_up ? s.count + COUNT_ONE : s.count - COUNT_ONE;
                end
                default: cnt_nx = s.count + COUNT_ONE;
            endcase
        end

        ovf = tick && step_up && (s.ovsel ? (s.count[14:0] == LOW15_MAX)
                                          : (s.count == COUNT_MAX));
        rmatch     = tick && (s.count == s.rstval);
        cmp_rst_ok = s.cren && (s.wctl[0][1:0] == OM_SINGLE) && !s.fsel[0] && s.fen[0];
        n.irq_req  = ovf || rmatch;

        if ((s.rren && rmatch) || (cmp_rst_ok && tick && (s.count == s.cmp[0])))
        begin
            cnt_nx  = COUNT_ZERO;
            n.down  = 1'b0;
            rst_evt = 1'b1;
        end

        wr_hit = s.wr_act && s.wr_ok;
        if (wr_hit && (s.wr_addr == OFF_COUNT) && s.run)
        begin
            cnt_nx = ahb_req.hwdata[15:0];
        end

        if (s.pren && !external_reset_pin)
        begin
            cnt_nx  = COUNT_ZERO;
            n.down  = 1'b0;
            rst_evt = 1'b1;
        end

        if (!s.run)
        begin
            cnt_nx    = COUNT_ZERO;
            n.down    = 1'b0;
            n.div_cnt = '0;
        end
        n.count = cnt_nx;

        if (tick)
        begin
            n.prb[0] = cnt_nx;
            n.prb[1] = cnt_nx;
        end

        // Channels
        n.chin = chan_in;
        for (int j = 0; j < NCH; j++)
        begin
            match[j] = tick && (s.count == s.cmp[j]);
        end
        for (int j = 0; j < NCH; j++)
        begin
            active = !s.fsel[j] && s.fen[j];
            case (s.wctl[j][1:0])
                OM_SINGLE:
                begin
                    if (match[j])
                        n.wave[j] = 1'b1;
                    else if (rst_evt || ovf)
                        n.wave[j] = 1'b0;
                end
                OM_DELAY:
                begin
                    if (match[j])
                        n.wave[j] = ~s.wave[j];
                end
                OM_SR:
                begin
                    if (j % 2 != 0)
                        n.wave[j] = 1'b0;
                    else if (match[j])
                        n.wave[j] = 1'b1;
                    else if (match[j | 1])
                        n.wave[j] = 1'b0;
                end
                default: n.wave[j] = 1'b0;
            endcase
            if ((j % 2 != 0) && (s.wctl[j - 1][1:0] == OM_SR))
                n.wave[j] = 1'b0;
            if (!active)
                n.wave[j] = 1'b0;
            n.pin[j]   = n.wave[j] ^ s.wctl[j][W_IVL] ^ s.wctl[j][W_INV];
            n.drive[j] = active;

            rise    = chan_in[j] && !s.chin[j];
            fall    = !chan_in[j] && s.chin[j];
            trig[j] = s.fsel[j] && s.fen[j] && ((s.mctl[j][0] && rise) || (s.mctl[j][1] && fall));
            if (j >= 6)
            begin
                if (s.mctl[j][M_GATE] && s.gate_closed[j - 6])
                    trig[j] = 1'b0;
                if (!s.mctl[j][M_GATE])
                    n.gate_closed[j - 6] = 1'b0;
                if (!s.mctl[j][M_PRE])
                    n.pre_cnt[j - 6] = '0;
                else if (trig[j])
                begin
                    if (s.pre_cnt[j - 6] >= s.mctl[j][M_PN +: 8])
                        n.pre_cnt[j - 6] = '0;
                    else
                    begin
                        n.pre_cnt[j - 6] = s.pre_cnt[j - 6] + 8'h01;
                        trig[j]          = 1'b0;
                    end
                end
                if (trig[j] && s.mctl[j][M_GATE])
                    n.gate_closed[j - 6] = 1'b1;
            end
            if (trig[j])
                n.cap[j] = s.count;
        end

        // Bus data phase write
        if (wr_hit)
        begin
            case (s.wr_addr[7:5])
                GRP_GLOBAL:
                begin
                    case (s.wr_addr)
                        OFF_CTRL0:
                        begin
                            n.css   = ahb_req.hwdata[C0_CSS +: 2];
                            n.rren  = ahb_req.hwdata[C0_RREN];
                            n.ovsel = ahb_req.hwdata[C0_OVSEL];
                        end
                        OFF_CTRL1:
                        begin
                            n.cren = ahb_req.hwdata[C1_CREN];
                            n.pren = ahb_req.hwdata[C1_PREN];
                            n.run  = ahb_req.hwdata[C1_RUN];
                            n.mode = ahb_req.hwdata[C1_MODE +: 2];
                        end
                        OFF_DIV:    n.div      = ahb_req.hwdata[7:0];
                        OFF_RSTVAL: n.rstval   = ahb_req.hwdata[15:0];
                        OFF_PCLK:   n.pclk_sel = ahb_req.hwdata[0];
                        OFF_FSEL:   n.fsel     = ahb_req.hwdata[7:0];
                        OFF_FEN:    n.fen      = ahb_req.hwdata[7:0];
                        default:    n.css      = s.css;
                    endcase
                end
                GRP_CMP:  n.cmp[ch] = ahb_req.hwdata[15:0];
                GRP_WCTL:
                begin
                    if (!(ch[0] && (s.wctl[{ch[2:1], 1'b0}][1:0] == OM_SR)))
                        n.wctl[ch] = ahb_req.hwdata[3:0];
                end
                GRP_MCTL:
                begin
                    if (ch >= PRE_CH_LO)
                    begin
                        n.mctl[ch] = ahb_req.hwdata[15:0] & MCTL_HI_MASK;
                        if (ahb_req.hwdata[M_GCLR])
                            n.gate_closed[ch[0]] = 1'b0;
                    end
                    else
                    begin
                        n.mctl[ch] = ahb_req.hwdata[15:0] & MCTL_LO_MASK;
                    end
                end
                default: n.css = s.css;
            endcase
        end

        // Bus address phase and read data
        case (ahb_req.haddr[7:5])
            GRP_GLOBAL:
            begin
                case (ahb_req.haddr[7:0])
                    OFF_COUNT:  rdat[15:0] = s.run ? s.count : COUNT_ZERO;
                    OFF_CTRL0:  rdat[3:0]  = {s.ovsel, s.rren, s.css};
                    OFF_CTRL1:  rdat[6:0]  = {s.mode, s.run, 2'h0, s.pren, s.cren};
                    OFF_DIV:    rdat[7:0]  = s.div;
                    OFF_RSTVAL: rdat[15:0] = s.rstval;
                    OFF_PCLK:   rdat[0]    = s.pclk_sel;
                    OFF_FSEL:   rdat[7:0]  = s.fsel;
                    OFF_FEN:    rdat[7:0]  = s.fen;
                    default:    rdat       = '0;
                endcase
            end
            GRP_CMP:  rdat[15:0] = s.cmp[rch];
            GRP_WCTL: rdat[3:0]  = s.wctl[rch];
            GRP_MCTL: rdat[15:0] = s.mctl[rch];
            GRP_CAP:  rdat[15:0] = s.cap[rch];
            GRP_PRB:  rdat[15:0] = (rch[2:1] == 2'h0) ? s.prb[rch[0]] : COUNT_ZERO;
            default:  rdat       = '0;
        endcase
        if (ahb_req.haddr[31:8] != '0)
            rdat = '0;

        addr_phase = ahb_req.hsel && ahb_req.hready && (ahb_req.htrans == HTRANS_NONSEQ);
        n.wr_act   = addr_phase && ahb_req.hwrite;
        n.wr_ok    = (ahb_req.haddr[31:8] == '0);
        n.wr_addr  = ahb_req.haddr[7:0];
        if (addr_phase && !ahb_req.hwrite)
            n.hrdata = rdat;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            s <= '0;
        else
            s <= n;
    end

endmodule

// ===== bench/icoc_chk.sv
`timescale 1ns/10ps
module icoc_chk
(
    input wire logic                    clk,
    input wire logic                    sys_rst,
    input wire icoc_pkg::icoc_ahb_req_t ahb_req,
    input wire icoc_pkg::icoc_ahb_rsp_t ahb_rsp,
    input wire logic                    phase_a_input,
    input wire logic                    phase_b_input,
    input wire logic                    external_reset_pin,
    input wire logic [7:0]              chan_in,
    input wire logic [7:0]              chan_out,
    input wire logic [7:0]              chan_oe_n,
    input wire logic                    base_irq_req
);
    import icoc_pkg::*;
    logic       ap_v, ap_w, run_q;
    logic [7:0] ap_a, fen_q, fsel_q;
    logic [1:0] css_q, css_d1, css_d2;
    wire        take = ahb_req.hsel && ahb_req.hready && ahb_req.htrans == HTRANS_NONSEQ;
    wire        rd_go = take && !ahb_req.hwrite;
    wire        low = ahb_req.haddr[31:8] == 24'h0;
    ////////////////////////////////////////////////////////////////////////////
    // Shadow of written control bits
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            {ap_v, ap_w, run_q, ap_a, fen_q, fsel_q} <= '0;
            {css_q, css_d1, css_d2} <= '0;
        end
        else
        begin
            ap_v <= take && low;
            ap_w <= ahb_req.hwrite;
            ap_a <= ahb_req.haddr[7:0];
            css_d1 <= css_q;
            css_d2 <= css_d1;
            if (ap_v && ap_w)
            begin
                case (ap_a)
                    OFF_CTRL0: css_q <= ahb_req.hwdata[1:0];
                    OFF_CTRL1: run_q <= ahb_req.hwdata[C1_RUN];
                    OFF_FSEL:  fsel_q <= ahb_req.hwdata[7:0];
                    OFF_FEN:   fen_q <= ahb_req.hwdata[7:0];
                    default:   ;
                endcase
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_ready_high: assert property (ahb_rsp.hreadyout)
        else $error("slave inserted wait");
    a_resp_okay: assert property (ahb_rsp.hresp == HRESP_OKAY)
        else $error("response not okay");
    a_unmapped_zero: assert property (rd_go && !low |=> ahb_rsp.hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (rd_go |=> ahb_rsp.hrdata[31:16] == 16'h0)
        else $error("upper read bits set");
    a_held_zero: assert property (rd_go && low && ahb_req.haddr[7:0] == OFF_COUNT && !run_q |=> ahb_rsp.hrdata == 32'h0)
        else $error("held count not zero");
    a_data_stands: assert property (!rd_go |=> $stable(ahb_rsp.hrdata))
        else $error("read data changed");
    a_stop_quiet: assert property (css_q == 2'h0 && css_d1 == 2'h0 && css_d2 == 2'h0 |-> !base_irq_req)
        else $error("request while stopped");
    a_drive_enable: assert property ($stable(fen_q) && $stable(fsel_q) |-> chan_oe_n == ~(fen_q & ~fsel_q))
        else $error("pin enable mismatch");
    a_mctl_low: assert property (rd_go && low && ahb_req.haddr[7:5] == GRP_MCTL && ahb_req.haddr[4:2] < PRE_CH_LO
        |=> ahb_rsp.hrdata[15:4] == 12'h0)
        else $error("prescaler bits on low channel");
endmodule
bind icoc_base_timer icoc_chk icoc_chk_i (.clk(clk), .sys_rst(sys_rst), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
    .phase_a_input(phase_a_input), .phase_b_input(phase_b_input), .external_reset_pin(external_reset_pin),
    .chan_in(chan_in), .chan_out(chan_out), .chan_oe_n(chan_oe_n), .base_irq_req(base_irq_req));

// ===== bench/icoc_enc.sv
`timescale 1ns/10ps
module icoc_enc
(
    input  wire logic       clk,
    input  wire logic [1:0] cmd,
    output logic            phase_a_input,
    output logic            phase_b_input,
    output logic            external_reset_pin
);
    logic [1:0] st = 2'h0;
    always_ff @(posedge clk)
    begin
        if (cmd == 2'h1)
            st <= st + 2'h1;
        else if (cmd == 2'h2)
            st <= st - 2'h1;
    end
    // Gray sequence: exactly one phase changes per step
    assign phase_a_input = st[1];
    assign phase_b_input = st[1] ^ st[0];
    // Pin has a pull-up, low only while commanded
    assign external_reset_pin = (cmd != 2'h3);
endmodule

// ===== bench/testbench.sv
`timescale 1ns/10ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin bad_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
    import icoc_pkg::*;
    logic          clk = 1'b0;
    logic          sys_rst = 1'b1;
    logic          hsel = 1'b0;
    logic          hwrite = 1'b0;
    logic [1:0]    htrans = 2'h0;
    logic [31:0]   haddr = 32'h0;
    logic [31:0]   hwdata = 32'h0;
    logic [1:0]    cmd = 2'h0;
    logic [31:0]   v;
    logic          pa, pb, pin, irq;
    logic [7:0]    cout, coe;
    logic [7:0]    cin = 8'h00;
    int            bad_count = 0;
    int            tests_run = 0;
    int            irqs;
    icoc_ahb_req_t req;
    icoc_ahb_rsp_t rsp;
    logic [15:0]   ov_start [3] = '{16'hFFF0, 16'h7FF0, 16'h7FF0};
    logic [31:0]   ov_ctl [3] = '{32'h1, 32'h1, 32'h9};
    int            ov_exp [3] = '{1, 0, 1};
    assign req = '{hsel, haddr, htrans, hwrite, 3'h2, hwdata, rsp.hreadyout};
    always #25 clk = ~clk;
    icoc_base_timer icoc_base_timer_i (.clk(clk), .sys_rst(sys_rst), .ahb_req(req), .ahb_rsp(rsp),
        .phase_a_input(pa), .phase_b_input(pb), .external_reset_pin(pin), .chan_in(cin),
        .chan_out(cout), .chan_oe_n(coe), .base_irq_req(irq));
    icoc_enc icoc_enc_i (.clk(clk), .cmd(cmd), .phase_a_input(pa), .phase_b_input(pb),
        .external_reset_pin(pin));
    ////////////////////////////////////////////////////////////////////////////
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge clk); while (rsp.hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (rsp.hreadyout !== 1'b1);
        v = rsp.hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer({24'h0, a}, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] a);
        xfer({24'h0, a}, 1'b0, 32'h0);
    endtask
    task automatic count_irq(input int cyc);
        irqs = 0;
        repeat (cyc)
        begin
            @(posedge clk);
            if (irq !== 1'b0)
                irqs++;
        end
    endtask
    // Two count reads exactly 40 cycles apart
    task automatic rate(input logic pc, input logic [7:0] dv, input logic [15:0] e);
        logic [15:0] v0;
        wr(OFF_PCLK, {31'h0, pc});
        wr(OFF_DIV, {24'h0, dv});
        rd(OFF_COUNT);
        v0 = v[15:0];
        repeat (38) @(posedge clk);
        rd(OFF_COUNT);
        `CHK(v[15:0] - v0, e)
    endtask
    task automatic step(input logic [1:0] c);
        repeat (6)
        begin
            cmd <= c;
            @(posedge clk);
            cmd <= 2'h0;
            repeat (3) @(posedge clk);
        end
    endtask
    task automatic close_out;
        if (bad_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        close_out();
    end
    initial
    begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(OFF_CTRL1);
        `CHK(v, 32'h0)
        `CHK(coe, 8'hFF)
        wr(OFF_COUNT, 32'h1234);
        rd(OFF_COUNT);
        `CHK(v, 32'h0)
        wr(OFF_FEN, 32'h5);
        wr(8'h48, 32'h4);
        repeat (2) @(posedge clk);
        `CHK(cout[2], 1'b1)
        wr(8'h48, 32'hC);
        repeat (2) @(posedge clk);
        `CHK(cout[2], 1'b0)
        `CHK(coe, 8'hFA)
        wr(8'h40, 32'h2);
        wr(8'h44, 32'h4);
        rd(8'h44);
        `CHK(v, 32'h0)
        wr(8'h40, 32'h0);
        wr(8'h60, 32'h3);
        rd(8'h60);
        `CHK(v, 32'h3)
        xfer(32'h100, 1'b0, 32'h0);
        wr(OFF_RSTVAL, 32'hC000);
        wr(OFF_CTRL1, 32'h10);
        wr(OFF_COUNT, 32'h1234);
        repeat (20) @(posedge clk);
        rd(OFF_COUNT);
        `CHK(v, 32'h1234)
        wr(OFF_CTRL0, 32'h1);
        rate(1'b1, 8'h0, 16'd40);
        rate(1'b1, 8'h3, 16'd10);
        rate(1'b0, 8'h3, 16'd5);
        rate(1'b0, 8'h0, 16'd20);
        wr(OFF_PCLK, 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            wr(OFF_CTRL0, ov_ctl[i]);
            wr(OFF_COUNT, {16'h0, ov_start[i]});
            count_irq(30);
            `CHK(irqs, ov_exp[i])
        end
        wr(OFF_CTRL1, 32'h30);
        wr(OFF_COUNT, 32'hFFF0);
        count_irq(60);
        `CHK(irqs, 0)
        rd(OFF_COUNT);
        `CHK(v[15:0] > 16'hFFB0 && v[15:0] < 16'hFFF0, 1'b1)
        wr(OFF_CTRL1, 32'h10);
        wr(OFF_COUNT, 32'h0);
        wr(OFF_RSTVAL, 32'h20);
        wr(OFF_CTRL0, 32'h5);
        count_irq(66);
        `CHK(irqs, 2)
        rd(OFF_COUNT);
        `CHK(v[15:0] <= 16'h20, 1'b1)
        wr(OFF_CTRL0, 32'h1);
        wr(8'h20, 32'h18);
        wr(OFF_CTRL1, 32'h11);
        wr(OFF_COUNT, 32'h0);
        repeat (40) @(posedge clk);
        rd(OFF_COUNT);
        `CHK(v[15:0] <= 16'h18, 1'b1)
        wr(OFF_FSEL, 32'h1);
        wr(OFF_COUNT, 32'h0);
        repeat (40) @(posedge clk);
        rd(OFF_COUNT);
        `CHK(v[15:0] > 16'h18, 1'b1)
        `CHK(coe[0], 1'b1)
        wr(OFF_CTRL1, 32'h12);
        cmd <= 2'h3;
        repeat (4) @(posedge clk);
        rd(OFF_COUNT);
        `CHK(v, 32'h0)
        cmd <= 2'h0;
        wr(OFF_CTRL0, 32'h0);
        wr(OFF_CTRL1, 32'h50);
        wr(OFF_COUNT, 32'h100);
        wr(OFF_CTRL0, 32'h2);
        step(2'h1);
        rd(OFF_COUNT);
        `CHK(v == 32'h106 || v == 32'hFA, 1'b1)
        step(2'h2);
        rd(OFF_COUNT);
        `CHK(v, 32'h100)
        rd(8'hA0);
        `CHK(v, 32'h100)
        wr(OFF_FSEL, 32'h41);
        wr(OFF_FEN, 32'h45);
        wr(8'h78, 32'h141);
        for (int i = 1; i < 4; i++)
        begin
            wr(OFF_COUNT, 32'h200 + i);
            cin <= 8'h40;
            @(posedge clk);
            cin <= 8'h00;
            @(posedge clk);
        end
        rd(8'h98);
        `CHK(v, 32'h202)
        close_out();
    end
endmodule
